// file: hdl/tbp_device.sv
// Display-side end of the parallel TFT register and pixel port
`include "tbp_cfg.svh"
module tbp_device #(
  parameter int COLS = `TBP_COLS,
  parameter int INIT_CYC = `TBP_INIT_CYC,
  parameter int PWM_PERIOD = `TBP_PWM_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host bus
  tbp_if.dev bus,
  // Frame memory
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [`TBP_PAGE_W-1:0] mem_page_o,
  output logic [`TBP_ADDR_W-1:0] mem_addr_o,
  output tbp_pkg::tbp_pixel_s mem_wdata_o,
  input wire logic [15:0] mem_rdata_i,
  // Panel side
  output logic [`TBP_PAGE_W-1:0] shown_page_o,
  output logic backlight_o,
  output logic ready_o
);
  localparam int IW = $clog2(INIT_CYC + 1);

  logic dev_rst;
  logic [IW-1:0] init_cnt_r;
  logic busy;
  logic wr_n_q_r;
  logic rd_n_q_r;
  logic wr_ev;
  logic rd_ev;
  logic idx_wr;
  logic val_wr;
  logic pix_wr;
  logic [15:0] ptr_r;
  logic [`TBP_LEVEL_W-1:0] level_r;
  logic [`TBP_ROW_W-1:0] start_row_r;
  logic [`TBP_COL_W-1:0] start_col_r;
  logic [`TBP_ROW_W-1:0] end_row_r;
  logic [`TBP_COL_W-1:0] end_col_r;
  logic dir_r;
  logic [`TBP_PAGE_W-1:0] shown_page_r;
  logic [`TBP_PAGE_W-1:0] access_page_r;
  logic [`TBP_ROW_W-1:0] row_r;
  logic [`TBP_COL_W-1:0] col_r;
  logic [`TBP_ROW_W-1:0] row_nxt;
  logic [`TBP_COL_W-1:0] col_nxt;
  logic mem_we_r;
  logic mem_re_r;
  logic rd_cap_r;
  logic [`TBP_ADDR_W-1:0] addr_r;
  tbp_pkg::tbp_pixel_s wdata_r;
  logic [15:0] rd_word_r;

  // Linear frame offset of a screen coordinate
  function automatic logic [`TBP_ADDR_W-1:0] frame_addr(
    input logic [`TBP_ROW_W-1:0] row,
    input logic [`TBP_COL_W-1:0] col
  );
    logic [31:0] lin;
    lin = 32'(row) * 32'(COLS) + 32'(col);
    return lin[`TBP_ADDR_W-1:0];
  endfunction

  // ------------------------------------------------------------
  // Reset pin and initialisation window
  // ------------------------------------------------------------
  // The pin is taken as synchronous; it resets everything the same as rst_i
  assign dev_rst = rst_i || !bus.rst_n;

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
      init_cnt_r <= '0;
    else if (busy)
      init_cnt_r <= init_cnt_r + 1'b1;
  end

  assign busy = int'(init_cnt_r) < INIT_CYC;
  assign ready_o = !busy;

  // ------------------------------------------------------------
  // Strobe detection
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      wr_n_q_r <= 1'b1;
      rd_n_q_r <= 1'b1;
    end
    else
    begin
      wr_n_q_r <= bus.wr_n;
      rd_n_q_r <= bus.rd_n;
    end
  end

  // Accesses during initialisation are dropped, the bus is not yet alive
  assign wr_ev = !busy && !bus.cs_n && wr_n_q_r && !bus.wr_n;
  assign idx_wr = wr_ev && !bus.index_data_select;
  assign val_wr = wr_ev && bus.index_data_select;
  assign pix_wr = val_wr && (ptr_r == `TBP_REG_PIXEL);
  assign rd_ev = !busy && !bus.cs_n && rd_n_q_r && !bus.rd_n && bus.index_data_select
    && (ptr_r == `TBP_REG_PIXEL);

  // ------------------------------------------------------------
  // Register pointer
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
      ptr_r <= 16'h0000;
    else if (idx_wr)
      ptr_r <= bus.bus_d;
  end

  // ------------------------------------------------------------
  // Command registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      level_r <= `TBP_LEVEL_RST;
      start_row_r <= '0;
      start_col_r <= '0;
      end_row_r <= '0;
      end_col_r <= '0;
      dir_r <= `TBP_DIR_ROW;
      shown_page_r <= `TBP_PAGE_RST;
      access_page_r <= `TBP_PAGE_RST;
    end
    else if (val_wr)
    begin
      if (ptr_r == `TBP_REG_BACKLIGHT)
      begin
        if (bus.bus_d <= 16'(`TBP_LEVEL_MAX))
          level_r <= bus.bus_d[`TBP_LEVEL_W-1:0];
      end
      else if (ptr_r == `TBP_REG_START_ROW)
        start_row_r <= bus.bus_d[`TBP_ROW_W-1:0];
      else if (ptr_r == `TBP_REG_START_COL)
        start_col_r <= bus.bus_d[`TBP_COL_W-1:0];
      else if (ptr_r == `TBP_REG_END_ROW)
        end_row_r <= bus.bus_d[`TBP_ROW_W-1:0];
      else if (ptr_r == `TBP_REG_END_COL)
        end_col_r <= bus.bus_d[`TBP_COL_W-1:0];
      else if (ptr_r == `TBP_REG_DIRECTION)
        dir_r <= bus.bus_d[0];
      else if (ptr_r == `TBP_REG_SHOWN_PAGE)
        shown_page_r <= bus.bus_d[`TBP_PAGE_W-1:0];
      else if (ptr_r == `TBP_REG_ACCESS_PAGE)
        access_page_r <= bus.bus_d[`TBP_PAGE_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Address advance inside the window
  // ------------------------------------------------------------
  always_comb
  begin
    row_nxt = row_r;
    col_nxt = col_r;
    if (dir_r == `TBP_DIR_ROW)
    begin
      // Past the last column, return to the first column of the next line
      if (col_r >= end_col_r)
      begin
        col_nxt = start_col_r;
        row_nxt = (row_r >= end_row_r) ? start_row_r : row_r + 1'b1;
      end
      else
        col_nxt = col_r + 1'b1;
    end
    else
    begin
      if (row_r >= end_row_r)
      begin
        row_nxt = start_row_r;
        col_nxt = (col_r >= end_col_r) ? start_col_r : col_r + 1'b1;
      end
      else
        row_nxt = row_r + 1'b1;
    end
  end

  // Selecting the pixel channel rearms the cursor at the window origin
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      row_r <= '0;
      col_r <= '0;
    end
    else if (idx_wr && (bus.bus_d == `TBP_REG_PIXEL))
    begin
      row_r <= start_row_r;
      col_r <= start_col_r;
    end
    else if (pix_wr || rd_ev)
    begin
      row_r <= row_nxt;
      col_r <= col_nxt;
    end
  end

  // ------------------------------------------------------------
  // Frame memory requests
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      mem_we_r <= 1'b0;
      mem_re_r <= 1'b0;
      rd_cap_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else
    begin
      mem_we_r <= pix_wr;
      mem_re_r <= rd_ev;
      rd_cap_r <= mem_re_r;
      if (pix_wr || rd_ev)
        addr_r <= frame_addr(row_r, col_r);
      if (pix_wr)
        wdata_r <= tbp_pkg::tbp_pixel_s'(bus.bus_d);
    end
  end

  // Memory answers one cycle after the read request
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
      rd_word_r <= 16'h0000;
    else if (rd_cap_r)
      rd_word_r <= mem_rdata_i;
  end

  assign mem_we_o = mem_we_r;
  assign mem_re_o = mem_re_r;
  assign mem_addr_o = addr_r;
  assign mem_wdata_o = wdata_r;
  assign mem_page_o = access_page_r;
  assign shown_page_o = shown_page_r;

  // ------------------------------------------------------------
  // Bus read data and backlight
  // ------------------------------------------------------------
  assign bus.dev_d = rd_word_r;
  assign bus.dev_d_oe = !busy && !bus.cs_n && !bus.rd_n && bus.index_data_select
    && (ptr_r == `TBP_REG_PIXEL);

  tbp_pwm #(
    .PERIOD(PWM_PERIOD),
    .LEVELS(int'(`TBP_LEVEL_MAX))
  ) u_pwm (
    .clock_i(clock_i),
    .rst_i(dev_rst),
    .level_i(level_r),
    .pwm_o(backlight_o)
  );
endmodule

// file: hdl/tbp_cfg.svh
// Register pointers, reset values, field widths and timing counts of the TFT bus port
`ifndef TBP_CFG_SVH
`define TBP_CFG_SVH

// ------------------------------------------------------------
// Register pointers
// ------------------------------------------------------------
`define TBP_REG_BACKLIGHT 16'h0001
`define TBP_REG_START_ROW 16'h0002
`define TBP_REG_START_COL 16'h0003
`define TBP_REG_SHOWN_PAGE 16'h0004
`define TBP_REG_ACCESS_PAGE 16'h0005
`define TBP_REG_END_ROW 16'h0006
`define TBP_REG_END_COL 16'h0007
`define TBP_REG_DIRECTION 16'h000D
`define TBP_REG_PIXEL 16'h000F

// ------------------------------------------------------------
// Field widths and reset values
// ------------------------------------------------------------
`define TBP_LEVEL_W 5
`define TBP_LEVEL_MAX 5'h10
`define TBP_LEVEL_RST 5'h00
`define TBP_ROW_W 9
`define TBP_COL_W 10
`define TBP_PAGE_W 3
`define TBP_PAGE_RST 3'h0
`define TBP_DIR_ROW 1'h0
`define TBP_DIR_COL 1'h1
`define TBP_ADDR_W 19
`define TBP_COLS 800

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TBP_CLK_KHZ 20000
`define TBP_PWM_HZ 300
`define TBP_RST_HOLD_US 1000
`define TBP_INIT_US 1000
`define TBP_PWM_PERIOD_CYC ((`TBP_CLK_KHZ * 1000) / `TBP_PWM_HZ)
`define TBP_RST_HOLD_CYC ((`TBP_RST_HOLD_US * `TBP_CLK_KHZ + 999) / 1000)
`define TBP_INIT_CYC ((`TBP_INIT_US * `TBP_CLK_KHZ + 999) / 1000)
`define TBP_STROBE_CYC 5

`endif

// file: hdl/tbp_pkg.sv
// Types of the TFT bus port: the host end's command kinds and the display end's pixel layout
package tbp_pkg;

  typedef enum logic [1:0] {
    TBP_CMD_INDEX,
    TBP_CMD_WRITE,
    TBP_CMD_READ
  } tbp_cmd_e;

  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } tbp_pixel_s;

endpackage

// file: hdl/tbp_if.sv
// Parallel 8080-style bus between host and display port
interface tbp_if;
  logic cs_n;
  logic index_data_select;
  logic wr_n;
  logic rd_n;
  logic rst_n;
  logic [15:0] host_d;
  logic host_d_oe;
  logic [15:0] dev_d;
  logic dev_d_oe;
  logic [15:0] bus_d;

  // Undriven bus floats high through the board pull-ups
  assign bus_d = host_d_oe ? host_d : (dev_d_oe ? dev_d : 16'hFFFF);

  modport host (
    output cs_n,
    output index_data_select,
    output wr_n,
    output rd_n,
    output rst_n,
    output host_d,
    output host_d_oe,
    input bus_d
  );

  modport dev (
    input cs_n,
    input index_data_select,
    input wr_n,
    input rd_n,
    input rst_n,
    output dev_d,
    output dev_d_oe,
    input bus_d
  );
endinterface

// file: hdl/tbp_pwm.sv
// Backlight pulse-width modulator with level 0 off and level LEVELS full on
`include "tbp_cfg.svh"
module tbp_pwm #(
  parameter int PERIOD = `TBP_PWM_PERIOD_CYC,
  parameter int LEVELS = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Level and output
  input wire logic [`TBP_LEVEL_W-1:0] level_i,
  output logic pwm_o
);
  localparam int CW = $clog2(PERIOD);
  localparam int STEP = PERIOD / LEVELS;

  logic [CW-1:0] cnt_r;
  logic pwm_r;

  always_ff @(posedge clock_i)
  begin
    if (rst_i || (int'(cnt_r) == PERIOD - 1))
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // Full level holds the line high the whole period, level 0 never
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pwm_r <= 1'b0;
    else if (int'(level_i) >= LEVELS)
      pwm_r <= 1'b1;
    else
      pwm_r <= int'(cnt_r) < int'(level_i) * STEP;
  end

  assign pwm_o = pwm_r;
endmodule

// file: hdl/tbp_host.sv
// Host-side end: drives the reset pin and runs index, write and read cycles
`include "tbp_cfg.svh"
module tbp_host #(
  parameter int RST_HOLD_CYC = `TBP_RST_HOLD_CYC,
  parameter int INIT_CYC = `TBP_INIT_CYC,
  parameter int STROBE_CYC = `TBP_STROBE_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Host bus
  tbp_if.host bus,
  // Command port
  input wire logic cmd_valid_i,
  input wire tbp_pkg::tbp_cmd_e cmd_kind_i,
  input wire logic [15:0] cmd_data_i,
  output logic cmd_ready_o,
  // Read answer
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o
);
  typedef enum logic [2:0] {
    TBP_ST_HOLD,
    TBP_ST_INIT,
    TBP_ST_IDLE,
    TBP_ST_STROBE,
    TBP_ST_GAP
  } tbp_state_e;

  localparam int CW = $clog2((RST_HOLD_CYC > INIT_CYC ? RST_HOLD_CYC : INIT_CYC) + 1);

  tbp_state_e state_r;
  logic [CW-1:0] cnt_r;
  logic rst_n_r;
  logic cs_n_r;
  logic sel_r;
  logic wr_n_r;
  logic rd_n_r;
  logic oe_r;
  logic [15:0] dout_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      state_r <= TBP_ST_HOLD;
      cnt_r <= '0;
    end
    else
    begin
      case (state_r)
        TBP_ST_HOLD:
          if (int'(cnt_r) >= RST_HOLD_CYC - 1)
          begin
            state_r <= TBP_ST_INIT;
            cnt_r <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        TBP_ST_INIT:
          if (int'(cnt_r) >= INIT_CYC)
          begin
            state_r <= TBP_ST_IDLE;
            cnt_r <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        TBP_ST_IDLE:
          if (cmd_valid_i)
            state_r <= TBP_ST_STROBE;
        TBP_ST_STROBE:
          if (int'(cnt_r) == STROBE_CYC - 1)
          begin
            state_r <= TBP_ST_GAP;
            cnt_r <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        default:
          state_r <= TBP_ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  // The caller owns the order of pointer and value cycles; this end never
  // reorders or inserts pointer writes, so a pixel stream stays on its pointer
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rst_n_r <= 1'b0;
      cs_n_r <= 1'b1;
      sel_r <= 1'b0;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      oe_r <= 1'b0;
      dout_r <= 16'h0000;
    end
    else
    begin
      rst_n_r <= (state_r != TBP_ST_HOLD) ||
        (int'(cnt_r) >= RST_HOLD_CYC - 1);
      if (state_r == TBP_ST_IDLE && cmd_valid_i)
      begin
        cs_n_r <= 1'b0;
        sel_r <= (cmd_kind_i != tbp_pkg::TBP_CMD_INDEX);
        wr_n_r <= (cmd_kind_i == tbp_pkg::TBP_CMD_READ);
        rd_n_r <= (cmd_kind_i != tbp_pkg::TBP_CMD_READ);
        oe_r <= (cmd_kind_i != tbp_pkg::TBP_CMD_READ);
        dout_r <= cmd_data_i;
      end
      else if (state_r == TBP_ST_STROBE && int'(cnt_r) == STROBE_CYC - 1)
      begin
        cs_n_r <= 1'b1;
        wr_n_r <= 1'b1;
        rd_n_r <= 1'b1;
        oe_r <= 1'b0;
      end
    end
  end

  // Read data is sampled on the last strobe edge
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end
    else
    begin
      rsp_valid_r <= state_r == TBP_ST_STROBE && int'(cnt_r) == STROBE_CYC - 1 && !rd_n_r;
      if (state_r == TBP_ST_STROBE && int'(cnt_r) == STROBE_CYC - 1 && !rd_n_r)
        rsp_data_r <= bus.bus_d;
    end
  end

  // Frame clearing before backlight is left to the command sequence of the caller
  assign cmd_ready_o = state_r == TBP_ST_IDLE;
  assign rsp_valid_o = rsp_valid_r;
  assign rsp_data_o = rsp_data_r;
  assign bus.rst_n = rst_n_r;
  assign bus.cs_n = cs_n_r;
  assign bus.index_data_select = sel_r;
  assign bus.wr_n = wr_n_r;
  assign bus.rd_n = rd_n_r;
  assign bus.host_d = dout_r;
  assign bus.host_d_oe = oe_r;
endmodule

// file: tb/tbp_sva.sv
// Assertions on the bus between the host and display ends
module tbp_sva #(
  parameter int INIT_CYC = 16
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Bus
  input wire logic cs_n,
  input wire logic index_data_select,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic rst_n,
  input wire logic [15:0] bus_d,
  input wire logic dev_d_oe,
  // Display outputs
  input wire logic mem_we_o,
  input wire logic [2:0] mem_page_o,
  input wire tbp_pkg::tbp_pixel_s mem_wdata_o,
  input wire logic [2:0] shown_page_o,
  input wire logic backlight_o,
  input wire logic ready_o
);
  logic dev_rst, wr_fall, pix_wr, wr_q_r;
  logic [15:0] ptr_r, data_q_r, cnt_r;
  logic [4:0] level_r;
  logic [2:0] page_r;

  // Display end also resets while its reset pin is low
  assign dev_rst = rst_i || !rst_n;
  // Strobes before the init window closes are ignored by the display end
  assign wr_fall = !cs_n && !wr_n && wr_q_r && ready_o;
  assign pix_wr = wr_fall && index_data_select && (ptr_r == 16'h000F);

  always_ff @(posedge clock_i)
  begin
    wr_q_r <= dev_rst ? 1'b1 : wr_n;
    data_q_r <= bus_d;
  end

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      ptr_r <= 16'h0000;
      level_r <= 5'h00;
      page_r <= 3'h0;
    end
    else if (wr_fall && !index_data_select)
    begin
      ptr_r <= bus_d;
    end
    else if (wr_fall && ptr_r == 16'h0001 && bus_d <= 16'h0010)
    begin
      level_r <= bus_d[4:0];
    end
    else if (wr_fall && ptr_r == 16'h0005)
    begin
      page_r <= bus_d[2:0];
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      cnt_r <= 16'h0000;
    end
    else if (cnt_r != 16'hFFFF)
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // --------
  // Checks
  // --------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (dev_rst);

  AST_WE_AFTER_WR: assert property (pix_wr |=> mem_we_o)
    else $error("pixel write lost");
  AST_WE_ONLY_PIXEL: assert property (mem_we_o |-> $past(pix_wr))
    else $error("stray memory write");
  AST_WE_ONE_PULSE: assert property (mem_we_o |=> !mem_we_o)
    else $error("memory write too long");
  AST_PIXEL_PACK:
    assert property (pix_wr |=> mem_wdata_o.red == data_q_r[15:11]
      && mem_wdata_o.green == data_q_r[10:5] && mem_wdata_o.blue == data_q_r[4:0])
    else $error("pixel fields misplaced");
  AST_BL_OFF: assert property ((level_r == 5'h00) [*4] |-> !backlight_o)
    else $error("backlight on at level zero");
  AST_BL_FULL: assert property ((level_r == 5'h10) [*4] |-> backlight_o)
    else $error("backlight not full at top level");
  AST_OE_ONLY_READ:
    assert property (dev_d_oe |-> !cs_n && !rd_n && index_data_select && ptr_r == 16'h000F)
    else $error("data driven outside pixel read");
  AST_READY_EARLY: assert property (cnt_r < INIT_CYC |-> !ready_o)
    else $error("ready too early");
  AST_READY_LATE: assert property (cnt_r == INIT_CYC |-> ready_o)
    else $error("ready too late");
  AST_SHOWN_PAGE:
    assert property (wr_fall && index_data_select && ptr_r == 16'h0004
      |=> shown_page_o == data_q_r[2:0])
    else $error("shown page not taken");
  AST_ACCESS_PAGE: assert property (mem_we_o |-> mem_page_o == page_r)
    else $error("wrong access page");

  COV_PIXEL: cover property (pix_wr);
  COV_READ: cover property (dev_d_oe);
  COV_FULL: cover property (level_r == 5'h10);
endmodule

// file: tb/tb_top.sv
// Bench joining the host and display ends through the bus interface
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PERIOD = 64;
  localparam int COLS = 800;

  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  tbp_pkg::tbp_cmd_e cmd_kind_i = tbp_pkg::TBP_CMD_INDEX;
  logic [15:0] cmd_data_i = 16'h0000;
  logic [15:0] mem_rdata_i = 16'hA5C3;
  logic cmd_ready_o, rsp_valid_o, mem_we_o, mem_re_o, backlight_o, ready_o;
  logic [15:0] rsp_data_o, rd_v;
  logic [2:0] mem_page_o, shown_page_o;
  logic [18:0] mem_addr_o;
  tbp_pkg::tbp_pixel_s mem_wdata_o;
  logic [18:0] addr_q[$];
  logic [15:0] data_q[$];
  logic [2:0] page_q[$];
  logic [15:0] pix[$] = '{16'hF800, 16'h07E0, 16'h001F, 16'hFFFF, 16'h8410};
  int failures = 0;
  int num_checks = 0;
  int rd_cnt = 0;
  logic [18:0] rd_addr = '0;

  always #25 clock_i = ~clock_i;

  tbp_if link();

  tbp_host #(.RST_HOLD_CYC(8), .INIT_CYC(16)) i_tbp_host (.clock_i(clock_i), .rst_i(rst_i),
    .bus(link), .cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o));

  tbp_device #(.INIT_CYC(16), .PWM_PERIOD(PERIOD)) i_tbp_device (.clock_i(clock_i),
    .rst_i(rst_i), .bus(link), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
    .mem_page_o(mem_page_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .shown_page_o(shown_page_o), .backlight_o(backlight_o),
    .ready_o(ready_o));

  tbp_sva #(.INIT_CYC(16)) i_tbp_sva (.clock_i(clock_i), .rst_i(rst_i), .cs_n(link.cs_n),
    .index_data_select(link.index_data_select), .wr_n(link.wr_n), .rd_n(link.rd_n),
    .rst_n(link.rst_n), .bus_d(link.bus_d), .dev_d_oe(link.dev_d_oe), .mem_we_o(mem_we_o),
    .mem_page_o(mem_page_o), .mem_wdata_o(mem_wdata_o), .shown_page_o(shown_page_o),
    .backlight_o(backlight_o), .ready_o(ready_o));

  always @(posedge clock_i)
  begin
    if (mem_we_o === 1'b1)
    begin
      addr_q.push_back(mem_addr_o);
      data_q.push_back(mem_wdata_o);
      page_q.push_back(mem_page_o);
    end
    // Read requests are counted so that refused reads can be told apart
    if (mem_re_o === 1'b1)
    begin
      rd_cnt++;
      rd_addr = mem_addr_o;
    end
  end

  // --------
  // Tasks
  // --------
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    failures++;
    $display("wrong value %s expected done seen timeout", what);
    summarize();
  endtask

  // Held until the host end takes it; valid drops one edge before the next command
  task automatic send(input tbp_pkg::tbp_cmd_e kind, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge clock_i);
    cmd_kind_i <= kind;
    cmd_data_i <= data;
    cmd_valid_i <= 1'b1;
    @(posedge clock_i);
    while (cmd_ready_o !== 1'b1)
    begin
      n++;
      if (n > 300)
        give_up("cmd_ready_o");
      @(posedge clock_i);
    end
    cmd_valid_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] ptr, input logic [15:0] val);
    send(tbp_pkg::TBP_CMD_INDEX, ptr);
    send(tbp_pkg::TBP_CMD_WRITE, val);
  endtask

  task automatic rd(output logic [15:0] v);
    int n;
    n = 0;
    send(tbp_pkg::TBP_CMD_READ, 16'h0000);
    while (rsp_valid_o !== 1'b1)
    begin
      n++;
      if (n > 50)
        give_up("rsp_valid_o");
      @(posedge clock_i);
    end
    v = rsp_data_o;
  endtask

  // Any full period holds level * PERIOD / 16 high cycles
  task automatic duty(input int lvl);
    int hi;
    hi = 0;
    repeat (12) @(posedge clock_i);
    repeat (PERIOD)
    begin
      @(posedge clock_i);
      if (backlight_o === 1'b1)
        hi++;
    end
    `CHK("backlight duty", lvl * (PERIOD / 16), hi)
  endtask

  task automatic stream(input int n);
    send(tbp_pkg::TBP_CMD_INDEX, 16'h000F);
    for (int i = 0; i < n; i++)
      send(tbp_pkg::TBP_CMD_WRITE, pix[i]);
  endtask

  task automatic expect_px(input int rows[$], input int cols[$], input logic [2:0] pg);
    logic [18:0] a;
    logic [15:0] v;
    logic [2:0] p;
    repeat (12) @(posedge clock_i);
    `CHK("pixel count", rows.size(), addr_q.size())
    foreach (rows[i])
    begin
      if (addr_q.size() > 0)
      begin
        a = addr_q.pop_front();
        v = data_q.pop_front();
        p = page_q.pop_front();
        `CHK("pixel address", 19'(rows[i] * COLS + cols[i]), a)
        `CHK("pixel data", pix[i], v)
        `CHK("pixel page", pg, p)
      end
    end
  endtask

  // --------
  // Sequence
  // --------
  initial
  begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    wr(16'h0002, 16'h0002);
    `CHK("shown page", 3'h0, shown_page_o)
    duty(0);
    wr(16'h0001, 16'h0008);
    duty(8);
    wr(16'h0001, 16'h0011);
    duty(8);
    wr(16'h0001, 16'h0010);
    duty(16);
    wr(16'h0001, 16'h0000);
    duty(0);
    wr(16'h0003, 16'h0005);
    wr(16'h0006, 16'h0003);
    wr(16'h0007, 16'h0006);
    wr(16'h000D, 16'h0000);
    stream(5);
    expect_px('{2, 2, 3, 3, 2}, '{5, 6, 5, 6, 5}, 3'h0);
    wr(16'h0005, 16'h0003);
    wr(16'h0004, 16'h0005);
    repeat (4) @(posedge clock_i);
    `CHK("shown page", 3'h5, shown_page_o)
    wr(16'h000D, 16'h0001);
    stream(3);
    expect_px('{2, 3, 2}, '{5, 5, 6}, 3'h3);
    wr(16'h0001, 16'h0008);
    send(tbp_pkg::TBP_CMD_WRITE, 16'h0004);
    duty(4);
    `CHK("pixel count", 0, addr_q.size())
    send(tbp_pkg::TBP_CMD_INDEX, 16'h000F);
    rd(rd_v);
    `CHK("pixel read", 16'hA5C3, rd_v)
    `CHK("read requests", 1, rd_cnt)
    `CHK("read address", 19'(2 * COLS + 5), rd_addr)
    send(tbp_pkg::TBP_CMD_INDEX, 16'h0002);
    rd(rd_v);
    `CHK("refused read", 16'hFFFF, rd_v)
    `CHK("read requests", 1, rd_cnt)
    summarize();
  end
endmodule
